// ==== core/epas_map.svh ====
// Register offsets, reset values and widths of the eight-pin port.
// Assumes inclusion by bare name from the package and the port modules.
`ifndef EPAS_MAP_SVH
`define EPAS_MAP_SVH

// Number of pins in the port.
`define EPAS_PINS 8

// Register offsets on the processor register bus.
`define EPAS_OFF_LATCH 16'h0004
`define EPAS_OFF_READBACK 16'h0011
`define EPAS_OFF_DIR 16'h0f1e
`define EPAS_OFF_PULLUP 16'h0f2b
`define EPAS_OFF_FSEL 16'h0f38

// Reset values of the writable registers.
`define EPAS_RST_LATCH 8'h00
`define EPAS_RST_DIR 8'h00
`define EPAS_RST_PULLUP 8'h00
`define EPAS_RST_FSEL 8'h00

// Value returned for an unmapped read.
`define EPAS_RD_UNMAPPED 8'h00

`endif

// ==== core/epas_pkg.sv ====
// Types shared by the eight-pin port with analog select.
// Assumes epas_map.svh is on the include path.
`default_nettype none

package epas_pkg;
	`include "epas_map.svh"

	// One bit per pin.
	typedef logic [`EPAS_PINS-1:0] epas_byte_t;

	// Register bus address.
	typedef logic [15:0] epas_addr_t;

	// Register selected by an address.
	typedef enum logic [2:0] {
		EPAS_SEL_NONE,
		EPAS_SEL_LATCH,
		EPAS_SEL_READBACK,
		EPAS_SEL_DIR,
		EPAS_SEL_PULLUP,
		EPAS_SEL_FSEL
	} epas_sel_t;
endpackage : epas_pkg

`default_nettype wire

// ==== core/epas_sync.sv ====
// Two-stage synchroniser for one pin level.
// Assumes the input is asynchronous to mclk and reset is synchronous.
`default_nettype none

module epas_sync (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// Asynchronous level in, synchronised level out.
	input wire logic async_in,
	output logic sync_out
);
	// First stage; only the second stage reads it.
	logic meta;

	// Both stages clear under reset so read-back starts at a known level.
	always_ff @(posedge mclk) begin
		if (reset) begin
			meta <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule : epas_sync

`default_nettype wire

// ==== core/epas_pin_cell.sv ====
// Steering logic of one port pin: driver, pull-up, analog and wakeup.
// Assumes the control bits come from registers on mclk.
`default_nettype none

module epas_pin_cell (
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// Control bits of this pin.
	input wire logic latch_bit,
	input wire logic pin_direction_bit,
	input wire logic pin_function_bit,
	input wire logic pullup_bit,
	input wire logic key_wakeup_enable_bit,
	// Pin side.
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	output logic pin_pullup,
	// Secondary functions and read-back.
	output logic analog_input_channel,
	output logic key_wakeup_input,
	output logic readback_bit
);
	// Pin level after two flip-flops.
	logic pin_sync;

	epas_sync u_sync (
		.mclk(mclk),
		.reset(reset),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	// The driver level is the latch bit itself.
	assign pin_out = latch_bit; // RQ3
	// Drive only as a port output; analog or wakeup use keeps it off.
	assign pin_oe = pin_direction_bit & ~pin_function_bit & ~key_wakeup_enable_bit; // RQ4
	// Pull-up connects only while the pin is an input.
	assign pin_pullup = pullup_bit & ~pin_direction_bit; // RQ9
	// Analog route, overridden while wakeup is enabled.
	assign analog_input_channel = pin_function_bit & ~key_wakeup_enable_bit; // RQ5
	// Wakeup sees the pin whatever the direction and function bits.
	assign key_wakeup_input = pin_sync & key_wakeup_enable_bit; // RQ6 RQ7
	// Read-back returns the pin only in plain port input mode.
	assign readback_bit = pin_sync & ~pin_direction_bit & ~pin_function_bit; // RQ11
endmodule : epas_pin_cell

`default_nettype wire

// ==== core/epas_port.sv ====
// Eight-pin general purpose port with analog select and wakeup sharing.
// Assumes a processor register port on mclk and a synchronous reset.
//
// Summary of operation
// (RQ1) Eight pins, each input or output.
// (RQ2) Pins also carry analog and wakeup inputs.
// (RQ3) Output pin drives its latch bit; latch resets 0.
// (RQ4) Direction 0 input, 1 output; reset 0.
// (RQ5) Function bit 1 routes pin to analog.
// (RQ6) Wakeup enabled works regardless of direction.
// (RQ7) Wakeup enabled works regardless of function bit.
// (RQ8) Per-pin pull-up usable only in input mode.
// (RQ9) Pull-up on only when enabled and input.
// (RQ10) Read-back gives pin in input, else 0.
// (RQ11) Read-back needs direction and function both 0.
// (RQ12) Bus writes update registers; reset restores them.
//
// Our own choice: the address-and-strobe port.
`default_nettype none
`include "epas_map.svh"

module epas_port
	import epas_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic reset,
	// Register port.
	input wire epas_pkg::epas_addr_t reg_addr,
	input wire epas_pkg::epas_byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output epas_pkg::epas_byte_t reg_rdata,
	// Pin side: input, driven level and output enable.
	input wire epas_pkg::epas_byte_t pin_in,
	output epas_pkg::epas_byte_t pin_out,
	output epas_pkg::epas_byte_t pin_oe,
	output epas_pkg::epas_byte_t pin_pullup,
	// Analog converter route enables.
	output epas_pkg::epas_byte_t analog_input_channel,
	// Wakeup controller side.
	input wire epas_pkg::epas_byte_t key_wakeup_enable_bit,
	output epas_pkg::epas_byte_t key_wakeup_input
);
	import epas_pkg::*;

	// Every control register lives here, not in the pin cells, so the read
	// multiplexer reaches all of them without routing back out of the loop.
	// The cost is a few byte-wide buses into the generate loop, which is
	// cheap at this size.
	// Output latch, one bit per pin.
	epas_byte_t port_output_latch;
	// Direction bits; 1 makes the pin an output.
	epas_byte_t port_direction_control;
	// Pull-up enable bits.
	epas_byte_t port_pullup_enable;
	// Function select bits; 1 routes the pin to the analog input.
	epas_byte_t port_function_select;
	// Live read-back value gathered from the pin cells.
	epas_byte_t port_input_readback;
	// Register picked by the current address.
	epas_sel_t sel;
	// Read data chosen in the cycle of the read strobe.
	epas_byte_t next_reg_rdata;

	// Address decode shared by the write and read paths.
	// The full 16-bit address is compared, so a register has no aliases.
	// An address that matches nothing selects no register: writes are lost
	// and reads return the unmapped value.
	always_comb begin
		case (reg_addr)
			`EPAS_OFF_LATCH: sel = EPAS_SEL_LATCH;
			`EPAS_OFF_READBACK: sel = EPAS_SEL_READBACK;
			`EPAS_OFF_DIR: sel = EPAS_SEL_DIR;
			`EPAS_OFF_PULLUP: sel = EPAS_SEL_PULLUP;
			`EPAS_OFF_FSEL: sel = EPAS_SEL_FSEL;
			default: sel = EPAS_SEL_NONE;
		endcase
	end

	// Output latch; writes land on the clock edge of the strobe.
	// The latch keeps its value while the pin is an input, ready for output.
	always_ff @(posedge mclk) begin
		if (reset) begin
			port_output_latch <= `EPAS_RST_LATCH; // RQ3
		end else if (reg_wr && sel == EPAS_SEL_LATCH) begin
			port_output_latch <= reg_wdata; // RQ12
		end
	end

	// Direction bits; all pins start as inputs.
	// Inputs at reset keep the port from fighting the board at power-up.
	always_ff @(posedge mclk) begin
		if (reset) begin
			port_direction_control <= `EPAS_RST_DIR; // RQ4
		end else if (reg_wr && sel == EPAS_SEL_DIR) begin
			port_direction_control <= reg_wdata; // RQ1
		end
	end

	// Pull-up enables; all disconnected after reset.
	// The enable is stored even on outputs; the cell gates it by direction.
	always_ff @(posedge mclk) begin
		if (reset) begin
			port_pullup_enable <= `EPAS_RST_PULLUP; // RQ9
		end else if (reg_wr && sel == EPAS_SEL_PULLUP) begin
			port_pullup_enable <= reg_wdata; // RQ8
		end
	end

	// Function select; all pins start with the port function.
	// Analog routing is only a steering bit; the converter lives elsewhere.
	always_ff @(posedge mclk) begin
		if (reset) begin
			port_function_select <= `EPAS_RST_FSEL; // RQ5
		end else if (reg_wr && sel == EPAS_SEL_FSEL) begin
			port_function_select <= reg_wdata; // RQ12
		end
	end

	// Read multiplexer; the read-back register ignores writes.
	// Every writable register reads back as written, so software may
	// read, modify and write single pins without a shadow copy.
	always_comb begin
		case (sel)
			EPAS_SEL_LATCH: next_reg_rdata = port_output_latch;
			EPAS_SEL_READBACK: next_reg_rdata = port_input_readback; // RQ10
			EPAS_SEL_DIR: next_reg_rdata = port_direction_control;
			EPAS_SEL_PULLUP: next_reg_rdata = port_pullup_enable;
			EPAS_SEL_FSEL: next_reg_rdata = port_function_select;
			default: next_reg_rdata = `EPAS_RD_UNMAPPED;
		endcase
	end

	// Read data stand only in the cycle after the strobe, else zero.
	// Clearing it between reads keeps stale pin levels off the bus.
	// A read of the pin levels therefore costs one cycle of latency.
	always_ff @(posedge mclk) begin
		if (reset) begin
			reg_rdata <= `EPAS_RD_UNMAPPED;
		end else if (reg_rd) begin
			reg_rdata <= next_reg_rdata;
		end else begin
			reg_rdata <= `EPAS_RD_UNMAPPED;
		end
	end

	// One cell per pin; all steering lives in the cell.
	// The cells share nothing, so a pin's mode never depends on its neighbours.
	// Each cell carries its own two-stage synchroniser for the pin level.
	for (genvar i = 0; i < `EPAS_PINS; i++) begin : g_pin
		epas_pin_cell u_cell (
			.mclk(mclk),
			.reset(reset),
			.latch_bit(port_output_latch[i]),
			.pin_direction_bit(port_direction_control[i]),
			.pin_function_bit(port_function_select[i]),
			.pullup_bit(port_pullup_enable[i]),
			.key_wakeup_enable_bit(key_wakeup_enable_bit[i]),
			.pin_in(pin_in[i]),
			.pin_out(pin_out[i]),
			.pin_oe(pin_oe[i]),
			.pin_pullup(pin_pullup[i]),
			.analog_input_channel(analog_input_channel[i]), // RQ2
			.key_wakeup_input(key_wakeup_input[i]), // RQ2
			.readback_bit(port_input_readback[i])
		);
	end

	// Checks below watch the outputs against the registers that cause them.
	// They are disabled during reset; the reset checks turn that off themselves.
	// Checks on pin_in lag by two cycles to match the synchronisers.
	// Read checks rely on the two strobes never standing together.
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	// A latch write shows on the driven level of every output pin.
	AST_LATCH_TO_PIN: assert property ( // RQ3
		reg_wr && sel == EPAS_SEL_LATCH
		|=> port_output_latch == $past(reg_wdata) && pin_out == $past(reg_wdata))
		else $error("latch write did not reach pin_out");

	// A direction write of all ones with nothing overriding drives every pin.
	AST_DIR_TO_OE: assert property ( // RQ1
		reg_wr && sel == EPAS_SEL_DIR && reg_wdata == 8'hff
		&& port_function_select == 8'h00
		##1 key_wakeup_enable_bit == 8'h00
		|-> pin_oe == 8'hff)
		else $error("direction write did not enable drivers");

	// No pin drives unless its direction bit is 1.
	AST_OE_NEEDS_DIR: assert property ( // RQ4
		(pin_oe & ~port_direction_control) == 8'h00)
		else $error("pin driven while in input mode");

	// Wakeup and analog use both keep the driver off.
	AST_OE_OVERRIDE: assert property ( // RQ7
		(pin_oe & (key_wakeup_enable_bit | port_function_select)) == 8'h00)
		else $error("pin driven while routed away");

	// Function write reaches the analog route on the next cycle.
	AST_FSEL_TO_ANALOG: assert property ( // RQ5
		reg_wr && sel == EPAS_SEL_FSEL ##1 key_wakeup_enable_bit == 8'h00
		|-> analog_input_channel == $past(reg_wdata))
		else $error("function write did not route analog input");

	// Each enabled wakeup bit tracks its pin two edges later, whatever the mode.
	// The first two edges after reset are skipped while the synchronisers refill.
	AST_WAKEUP_FOLLOWS_PIN: assert property ( // RQ6
		!$past(reset) && !$past(reset, 2)
		|-> key_wakeup_input == ($past(pin_in, 2) & key_wakeup_enable_bit))
		else $error("wakeup input lost the pin level");

	// Pull-up never connects on an output pin.
	AST_PULLUP_INPUT_ONLY: assert property ( // RQ9
		(pin_pullup & port_direction_control) == 8'h00
		&& (pin_pullup & ~port_pullup_enable) == 8'h00)
		else $error("pull-up connected outside input mode");

	// A pull-up write on input pins connects them next cycle.
	AST_PULLUP_WRITE: assert property ( // RQ8
		reg_wr && sel == EPAS_SEL_PULLUP && port_direction_control == 8'h00
		|=> pin_pullup == $past(reg_wdata))
		else $error("pull-up write had no effect on input pins");

	// Read-back masks every pin that is not a plain port input.
	AST_READBACK_MASK: assert property ( // RQ11
		reg_rd && sel == EPAS_SEL_READBACK
		|=> (reg_rdata & ($past(port_direction_control)
		| $past(port_function_select))) == 8'h00)
		else $error("read-back returned a non-input pin");

	// A steady input pin reads back its level.
	AST_READBACK_LEVEL: assert property ( // RQ10
		(pin_in == 8'h5a && port_direction_control == 8'h00
		&& port_function_select == 8'h00) [*3]
		##0 reg_rd && sel == EPAS_SEL_READBACK
		|=> reg_rdata == 8'h5a)
		else $error("read-back did not show the pin level");

	// Read data stand for one cycle only.
	AST_READ_ONE_CYCLE: assert property ( // RQ12
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data held beyond one cycle");

	// Reset restores every writable register.
	AST_RESET_VALUES: assert property (disable iff (1'b0) // RQ12
		reset |=> port_output_latch == 8'h00 && port_direction_control == 8'h00
		&& port_pullup_enable == 8'h00 && port_function_select == 8'h00)
		else $error("register not cleared by reset");

	// A direction write lands whole on the next cycle.
	AST_DIR_WRITE: assert property ( // RQ4
		reg_wr && sel == EPAS_SEL_DIR |=> port_direction_control == $past(reg_wdata))
		else $error("direction write did not land");

	// A function write lands whole on the next cycle.
	AST_FSEL_WRITE: assert property ( // RQ12
		reg_wr && sel == EPAS_SEL_FSEL |=> port_function_select == $past(reg_wdata))
		else $error("function write did not land");

	// The latch holds unless it is written.
	AST_LATCH_HOLD: assert property ( // RQ12
		!(reg_wr && sel == EPAS_SEL_LATCH) |=> $stable(port_output_latch))
		else $error("output latch changed without a write");

	// The direction bits hold unless they are written.
	AST_DIR_HOLD: assert property ( // RQ12
		!(reg_wr && sel == EPAS_SEL_DIR) |=> $stable(port_direction_control))
		else $error("direction bits changed without a write");

	// The pull-up enables hold unless they are written.
	AST_PULLUP_HOLD: assert property ( // RQ12
		!(reg_wr && sel == EPAS_SEL_PULLUP) |=> $stable(port_pullup_enable))
		else $error("pull-up enables changed without a write");

	// The function bits hold unless they are written.
	AST_FSEL_HOLD: assert property ( // RQ12
		!(reg_wr && sel == EPAS_SEL_FSEL) |=> $stable(port_function_select))
		else $error("function bits changed without a write");

	// Writes to the read-back place or to no register change nothing.
	AST_WRITE_REFUSED: assert property ( // RQ10
		reg_wr && (sel == EPAS_SEL_READBACK || sel == EPAS_SEL_NONE)
		|=> $stable(port_output_latch) && $stable(port_direction_control)
		&& $stable(port_pullup_enable) && $stable(port_function_select))
		else $error("refused write changed a register");

	// A read of no register returns the unmapped value.
	AST_UNMAPPED_READ: assert property ( // RQ10
		reg_rd && sel == EPAS_SEL_NONE |=> reg_rdata == 8'h00)
		else $error("unmapped read returned data");

	// The latch reads back as it stood at the read strobe.
	AST_READ_LATCH: assert property ( // RQ12
		reg_rd && sel == EPAS_SEL_LATCH |=> reg_rdata == $past(port_output_latch))
		else $error("latch read returned a wrong value");

	// The direction bits read back as they stood at the read strobe.
	AST_READ_DIR: assert property ( // RQ4
		reg_rd && sel == EPAS_SEL_DIR |=> reg_rdata == $past(port_direction_control))
		else $error("direction read returned a wrong value");

	// The pull-up enables read back as they stood at the read strobe.
	AST_READ_PULLUP: assert property ( // RQ9
		reg_rd && sel == EPAS_SEL_PULLUP |=> reg_rdata == $past(port_pullup_enable))
		else $error("pull-up read returned a wrong value");

	// The function bits read back as they stood at the read strobe.
	AST_READ_FSEL: assert property ( // RQ5
		reg_rd && sel == EPAS_SEL_FSEL |=> reg_rdata == $past(port_function_select))
		else $error("function read returned a wrong value");

	// No analog route without its function bit.
	AST_ANALOG_NEEDS_FSEL: assert property ( // RQ5
		(analog_input_channel & ~port_function_select) == 8'h00)
		else $error("analog route without function bit");

	// An enabled wakeup input takes the pin away from the analog route.
	AST_ANALOG_OFF_WAKEUP: assert property ( // RQ7
		(analog_input_channel & key_wakeup_enable_bit) == 8'h00)
		else $error("analog route while wakeup enabled");

	// A wakeup input stays low unless it is enabled.
	AST_WAKE_NEEDS_ENABLE: assert property ( // RQ6
		(key_wakeup_input & ~key_wakeup_enable_bit) == 8'h00)
		else $error("wakeup input active while disabled");

	// With every pin an input, the pull-ups follow their enables.
	AST_PULLUP_FOLLOWS: assert property ( // RQ9
		port_direction_control == 8'h00 |-> pin_pullup == port_pullup_enable)
		else $error("pull-up did not follow its enable");

	// Reset leaves no driver, no pull-up, no read data and no wakeup level.
	AST_RESET_OUTPUTS: assert property (disable iff (1'b0) // RQ12
		reset |=> pin_oe == 8'h00 && pin_pullup == 8'h00 && reg_rdata == 8'h00
		&& key_wakeup_input == 8'h00)
		else $error("output active after reset");

	// Main scenarios: all pins driving, pull-up used, analog routed, read-back.
	// A fifth cover watches a wakeup level passing through.
	COV_ALL_OUTPUT: cover property (pin_oe == 8'hff);
	COV_PULLUP: cover property (pin_pullup != 8'h00);
	COV_ANALOG: cover property (analog_input_channel != 8'h00);
	COV_WAKEUP: cover property (key_wakeup_input != 8'h00);
	COV_READBACK: cover property (reg_rd && sel == EPAS_SEL_READBACK
		##1 reg_rdata != 8'h00);
endmodule : epas_port

`default_nettype wire

// ==== sim/epas_board.sv ====
// Board circuitry model on the eight port pins.
// Assumes mclk from the bench; the bench must not drive a pin the port drives.
`default_nettype none

module epas_board
	import epas_pkg::*;
(
	// Clock.
	input wire logic mclk,
	// Port side of the pins.
	input wire epas_pkg::epas_byte_t pin_out,
	input wire epas_pkg::epas_byte_t pin_oe,
	input wire epas_pkg::epas_byte_t pin_pullup,
	// External drivers commanded by the bench.
	input wire epas_pkg::epas_byte_t drv_en,
	input wire epas_pkg::epas_byte_t drv_val,
	// Resolved pin level.
	output epas_pkg::epas_byte_t pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	epas_byte_t float_lvl = 8'h00; // Undriven pins wander, so nothing reads a stale level.

	// A floating pin flips every cycle rather than holding its last value.
	always_ff @(posedge mclk) begin
		float_lvl <= ~float_lvl;
	end

	// The port wins, then the board, then the pull-up, else the pin floats.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : drv_en[i] ? drv_val[i] :
				pin_pullup[i] ? 1'b1 : float_lvl[i];
		end
	end
endmodule : epas_board

`default_nettype wire

// ==== sim/epas_port_tb_top.sv ====
// Self-checking bench of the eight-pin port with analog select.
// Assumes the board model beside the port and a 40 MHz clock.
`default_nettype none
`include "epas_map.svh"

module epas_port_tb_top;
	import epas_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0; // System clock.
	logic reset = 1'b1; // Synchronous reset.
	epas_addr_t reg_addr = 16'h0000; // Register address.
	epas_byte_t reg_wdata = 8'h00; // Write data.
	logic reg_wr = 1'b0; // Write strobe.
	logic reg_rd = 1'b0; // Read strobe.
	epas_byte_t reg_rdata, pin_in, pin_out, pin_oe, pin_pullup, analog, wake_in;
	epas_byte_t wake_en = 8'h00; // Wakeup enables.
	epas_byte_t drv_en = 8'h00; // Board driver enables.
	epas_byte_t drv_val = 8'h00; // Board driver levels.
	int err_count = 0; // Mismatches.
	int checked = 0; // Comparisons.

	// A 25 ns period.
	always #12.5 mclk = ~mclk;

	epas_port dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
		.analog_input_channel(analog), .key_wakeup_enable_bit(wake_en),
		.key_wakeup_input(wake_in));
	epas_board board (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .drv_en(drv_en), .drv_val(drv_val), .pin_in(pin_in));

	// Compare one value and report a difference at once.
	task automatic chk(input string name, input epas_byte_t seen, input epas_byte_t exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// One write cycle; returns once the new value is visible.
	task automatic wr(input epas_addr_t a, input epas_byte_t d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	// One read cycle; the data stand only in the cycle after the strobe.
	task automatic rd(input epas_addr_t a, output epas_byte_t d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	// Read a register and compare it.
	task automatic rchk(input string name, input epas_addr_t a, input epas_byte_t exp);
		epas_byte_t d;
		rd(a, d);
		chk(name, d, exp);
	endtask : rchk

	// Every writable register and the output enables at their reset values.
	task automatic t_reset_state();
		rchk("latch", `EPAS_OFF_LATCH, 8'h00);
		rchk("dir", `EPAS_OFF_DIR, 8'h00);
		rchk("fsel", `EPAS_OFF_FSEL, 8'h00);
		rchk("pullup", `EPAS_OFF_PULLUP, 8'h00);
		chk("oe", pin_oe, 8'h00);
		$display("test reset_state done");
	endtask : t_reset_state

	// Outputs drive the latch; read-back gives 0 on output pins.
	task automatic t_output();
		wr(`EPAS_OFF_DIR, 8'hff);
		wr(`EPAS_OFF_LATCH, 8'ha5);
		chk("oe", pin_oe, 8'hff);
		chk("out", pin_out, 8'ha5);
		rchk("latch", `EPAS_OFF_LATCH, 8'ha5);
		rchk("readback", `EPAS_OFF_READBACK, 8'h00);
		$display("test output done");
	endtask : t_output

	// Mixed directions with pull-ups: only inputs get them and read live levels.
	task automatic t_input_pullup();
		wr(`EPAS_OFF_DIR, 8'h0f);
		wr(`EPAS_OFF_PULLUP, 8'hff);
		chk("pullup pins", pin_pullup, 8'hf0);
		@(posedge mclk);
		drv_en <= 8'h30;
		drv_val <= 8'h00;
		repeat (4) @(posedge mclk);
		rchk("readback", `EPAS_OFF_READBACK, 8'hc0);
		wr(`EPAS_OFF_PULLUP, 8'h00);
		chk("pullup off", pin_pullup, 8'h00);
		$display("test input_pullup done");
	endtask : t_input_pullup

	// Function bits route to analog, drop the driver and mask read-back.
	task automatic t_function();
		@(posedge mclk);
		drv_en <= 8'hf0;
		drv_val <= 8'hf0;
		wr(`EPAS_OFF_FSEL, 8'h33);
		chk("analog", analog, 8'h33);
		chk("oe", pin_oe, 8'h0c);
		repeat (4) @(posedge mclk);
		rchk("readback", `EPAS_OFF_READBACK, 8'hc0);
		$display("test function done");
	endtask : t_function

	// Wakeup works on output pins whatever the function bits say.
	task automatic t_wakeup();
		@(posedge mclk);
		wake_en <= 8'h81;
		drv_en <= 8'h81;
		drv_val <= 8'h81;
		wr(`EPAS_OFF_FSEL, 8'h00);
		wr(`EPAS_OFF_DIR, 8'hff);
		repeat (4) @(posedge mclk);
		#1;
		chk("oe", pin_oe, 8'h7e);
		chk("wake", wake_in, 8'h81);
		wr(`EPAS_OFF_FSEL, 8'hff);
		chk("analog", analog, 8'h7e);
		chk("wake", wake_in, 8'h81);
		@(posedge mclk);
		wake_en <= 8'h00;
		drv_en <= 8'h00;
		$display("test wakeup done");
	endtask : t_wakeup

	// Writes to the read-only and unmapped places change nothing.
	task automatic t_refused();
		wr(`EPAS_OFF_READBACK, 8'h5a);
		wr(16'h0005, 8'h5a);
		rchk("unmapped", 16'h0005, 8'h00);
		rchk("latch", `EPAS_OFF_LATCH, 8'ha5);
		$display("test refused done");
	endtask : t_refused

	// Plain inputs: a pull-up write connects at once and pins read live.
	task automatic t_input_level();
		wr(`EPAS_OFF_DIR, 8'h00);
		wr(`EPAS_OFF_FSEL, 8'h00);
		wr(`EPAS_OFF_PULLUP, 8'h0f);
		chk("pullup in", pin_pullup, 8'h0f);
		chk("analog off", analog, 8'h00);
		@(posedge mclk);
		drv_en <= 8'hff;
		drv_val <= 8'h5a;
		repeat (4) @(posedge mclk);
		rchk("level", `EPAS_OFF_READBACK, 8'h5a);
		chk("wake off", wake_in, 8'h00);
		$display("test input_level done");
	endtask : t_input_level

	// Reset in mid-run clears the function select and the output latch.
	task automatic t_midreset();
		@(posedge mclk);
		reset <= 1'b1;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		rchk("fsel", `EPAS_OFF_FSEL, 8'h00);
		rchk("latch", `EPAS_OFF_LATCH, 8'h00);
		chk("out", pin_out, 8'h00);
		$display("test midreset done");
	endtask : t_midreset

	// Counts, verdict and end of run.
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test

	// Main sequence after two cycles of reset.
	initial begin
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		t_reset_state();
		t_output();
		t_input_pullup();
		t_function();
		t_wakeup();
		t_refused();
		t_input_level();
		t_midreset();
		finish_test();
	end

	// The tests take about 80 cycles; 3000 means a hang.
	initial begin
		#75000;
		err_count++;
		finish_test();
	end
endmodule : epas_port_tb_top

`default_nettype wire
